// file: hw/bmlp_boot_lp.sv
// boot mode selection, serial loader and stop/wait sequencing
// assumes ref_clk is the oscillator; ram, cpu and peripherals outside
`timescale 1ns/1ns
`include "bmlp_defines.svh"
module bmlp_boot_lp
  import bmlp_pkg::*;
#(
  parameter bit LONG_STAB = 1'b1,
  parameter bit WDOG_IN_WAIT = 1'b0
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic irqHighVolt,
  input wire logic captureOneInput,
  input wire logic bootStrapHigh,
  input wire logic bootStrapLow,
  input wire logic securityOptionBit,
  input wire logic [7:0] portA,
  input wire logic [7:0] portB,
  input wire logic [7:0] portC,
  input wire logic serialRx,
  input wire logic stopExec,
  input wire logic waitExec,
  input wire bmlp_irq_t irqIn,
  input wire logic nvmErased,
  input wire logic [7:0] nvmRawData,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWe,
  input wire logic regRe,
  output logic [7:0] regRdata,
  output bmlp_ram_t ramWr,
  output logic [7:0] nvmData,
  output logic execStart,
  output logic [15:0] execAddr,
  output logic clearIMask,
  output logic stackReq,
  output logic busClkEn,
  output bmlp_lp_out_t lpOut,
  output bmlp_mode_t bootMode
);

// ----------------------------------------
// mode capture
// ----------------------------------------
logic captured_r;
bmlp_mode_t mode_r;
bmlp_mode_t modeSel;

always_comb begin
  modeSel = BMLP_SINGLE;
  if (irqHighVolt && captureOneInput && bootStrapHigh) begin
    if (bootStrapLow) begin
      modeSel = BMLP_JUMP;
    end else if (securityOptionBit) begin
      modeSel = BMLP_LOADER;
    end else begin
      modeSel = BMLP_BLOCKED;
    end
  end
end

always_ff @(posedge ref_clk or negedge rst_n) begin
  if (!rst_n) begin
    captured_r <= 1'b0;
    mode_r <= BMLP_SINGLE;
  end else if (!captured_r) begin
    captured_r <= 1'b1;
    mode_r <= modeSel;
  end
end

assign bootMode = mode_r;

// ----------------------------------------
// control register
// ----------------------------------------
logic slow_r;
logic xie_r;
logic stopEnter;
logic waitEnter;
bmlp_lp_t lp_r;

always_ff @(posedge ref_clk or negedge rst_n) begin
  if (!rst_n) begin
    slow_r <= 1'b0;
    xie_r <= 1'b1;
  end else if (stopEnter) begin
    slow_r <= 1'b0;
  end else if (regWe && regAddr == `BMLP_ADDR_CTRL) begin
    slow_r <= regWdata[`BMLP_CTRL_SLOW];
    xie_r <= regWdata[`BMLP_CTRL_XIE];
  end
end

// ----------------------------------------
// bus clock divider
// ----------------------------------------
logic [4:0] div_r;
logic [4:0] divTop;

assign divTop = slow_r ? `BMLP_DIV_SLOW : `BMLP_DIV_NORM;

always_ff @(posedge ref_clk or negedge rst_n) begin
  if (!rst_n) begin
    div_r <= 5'h00;
  end else if (lp_r == LP_STOP || div_r >= divTop) begin
    div_r <= 5'h00;
  end else begin
    div_r <= div_r + 5'h01;
  end
end

assign busClkEn = (lp_r != LP_STOP) && (div_r >= divTop);

// ----------------------------------------
// serial receiver
// ----------------------------------------
bmlp_rx_t rx_r;
logic [11:0] bitCnt_r;
logic [2:0] bitIdx_r;
logic [7:0] shift_r;
logic rxDone;
logic rxRun;

assign rxRun = (mode_r == BMLP_LOADER) && (lp_r != LP_STOP);
assign rxDone = (rx_r == RX_STOP) && (bitCnt_r == 12'(`BMLP_BIT_CYC - 1)) && serialRx;

always_ff @(posedge ref_clk or negedge rst_n) begin
  if (!rst_n) begin
    rx_r <= RX_IDLE;
    bitCnt_r <= 12'h000;
    bitIdx_r <= 3'h0;
    shift_r <= 8'h00;
  end else if (!rxRun) begin
    rx_r <= RX_IDLE;
  end else begin
    unique case (rx_r)
      RX_IDLE: begin
        bitCnt_r <= 12'h000;
        if (!serialRx) begin
          rx_r <= RX_START;
        end
      end
      RX_START: begin
        bitCnt_r <= bitCnt_r + 12'h001;
        if (bitCnt_r == 12'(`BMLP_HALF_CYC - 1)) begin
          bitCnt_r <= 12'h000;
          bitIdx_r <= 3'h0;
          rx_r <= serialRx ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        bitCnt_r <= bitCnt_r + 12'h001;
        if (bitCnt_r == 12'(`BMLP_BIT_CYC - 1)) begin
          bitCnt_r <= 12'h000;
          shift_r <= {serialRx, shift_r[7:1]};
          bitIdx_r <= bitIdx_r + 3'h1;
          if (bitIdx_r == 3'h7) begin
            rx_r <= RX_STOP;
          end
        end
      end
      RX_STOP: begin
        bitCnt_r <= bitCnt_r + 12'h001;
        if (bitCnt_r == 12'(`BMLP_BIT_CYC - 1)) begin
          rx_r <= RX_IDLE;
        end
      end
    endcase
  end
end

// ----------------------------------------
// ram loader
// ----------------------------------------
logic [7:0] count_r;
logic [7:0] got_r;
logic loadDone_r;
logic [15:0] loadPtr_r;

always_ff @(posedge ref_clk or negedge rst_n) begin
  if (!rst_n) begin
    count_r <= 8'h00;
    got_r <= 8'h00;
    loadDone_r <= 1'b0;
    loadPtr_r <= `BMLP_RAM_BASE;
    ramWr <= '0;
  end else begin
    ramWr.we <= 1'b0;
    if (rxDone && !loadDone_r) begin
      ramWr.we <= 1'b1;
      ramWr.addr <= loadPtr_r;
      ramWr.data <= shift_r;
      loadPtr_r <= loadPtr_r + 16'h0001;
      got_r <= got_r + 8'h01;
      if (got_r == 8'h00) begin
        count_r <= shift_r;
      end
      if (got_r != 8'h00 && got_r + 8'h01 == count_r) begin
        loadDone_r <= 1'b1;
      end
    end
  end
end

// ----------------------------------------
// start of execution
// ----------------------------------------
logic started_r;
logic loadFinish;
logic [15:0] wakeVec_r;

assign loadFinish = rxDone && !loadDone_r && got_r != 8'h00 && got_r + 8'h01 == count_r;

always_ff @(posedge ref_clk or negedge rst_n) begin
  if (!rst_n) begin
    started_r <= 1'b0;
    execStart <= 1'b0;
    execAddr <= `BMLP_VEC_RST;
  end else begin
    execStart <= 1'b0;
    if (lp_r == LP_RESUME) begin
      execStart <= 1'b1;
      execAddr <= wakeVec_r;
    end else if (captured_r && !started_r) begin
      unique case (mode_r)
        BMLP_SINGLE, BMLP_BLOCKED: begin
          started_r <= 1'b1;
          execStart <= 1'b1;
          execAddr <= `BMLP_VEC_RST;
        end
        BMLP_JUMP: begin
          if (portA == `BMLP_JUMP_KEY) begin
            started_r <= 1'b1;
            execStart <= 1'b1;
            execAddr <= {portB, portC};
          end
        end
        BMLP_LOADER: begin
          if (loadFinish) begin
            started_r <= 1'b1;
            execStart <= 1'b1;
            execAddr <= `BMLP_PROG_START;
          end
        end
      endcase
    end
  end
end

// ----------------------------------------
// stop and wait sequencer
// ----------------------------------------
logic [11:0] stab_r;
logic [11:0] stabLen;
logic waitWake;
logic stopWake;

assign stabLen = LONG_STAB ? `BMLP_STAB_LONG : `BMLP_STAB_SHORT;
assign stopWake = irqIn.wake && xie_r;
assign waitWake = (irqIn.wake && xie_r) || irqIn.timer || irqIn.sci;
assign stopEnter = lp_r == LP_RUN && stopExec;
assign waitEnter = lp_r == LP_RUN && waitExec && !stopExec;

always_ff @(posedge ref_clk or negedge rst_n) begin
  if (!rst_n) begin
    lp_r <= LP_RUN;
    stab_r <= 12'h000;
    wakeVec_r <= `BMLP_VEC_RST;
  end else begin
    unique case (lp_r)
      LP_RUN: begin
        if (stopEnter) begin
          lp_r <= LP_STOP;
        end else if (waitEnter) begin
          lp_r <= LP_WAIT;
        end
      end
      LP_STOP: begin
        stab_r <= 12'h000;
        if (stopWake) begin
          lp_r <= LP_STAB;
          wakeVec_r <= `BMLP_VEC_IRQ;
        end
      end
      LP_STAB: begin
        if (busClkEn) begin
          stab_r <= stab_r + 12'h001;
          if (stab_r == stabLen - 12'h001) begin
            lp_r <= LP_RESUME;
          end
        end
      end
      LP_WAIT: begin
        if (waitWake) begin
          lp_r <= LP_RUN;
        end
      end
      LP_RESUME: begin
        lp_r <= LP_RUN;
      end
    endcase
  end
end

always_ff @(posedge ref_clk or negedge rst_n) begin
  if (!rst_n) begin
    clearIMask <= 1'b0;
    stackReq <= 1'b0;
  end else begin
    clearIMask <= stopEnter || waitEnter;
    stackReq <= lp_r == LP_RESUME || (lp_r == LP_WAIT && waitWake);
  end
end

always_comb begin
  lpOut.oscOn = lp_r != LP_STOP;
  lpOut.cpuHold = lp_r != LP_RUN;
  lpOut.periphHalt = lp_r == LP_STOP || lp_r == LP_STAB;
  lpOut.wdogClear = lp_r == LP_STOP || (lp_r == LP_WAIT && !WDOG_IN_WAIT);
  lpOut.nvmReadOnly = lp_r == LP_STOP;
  lpOut.pulseLenHold = lp_r == LP_STOP;
end

assign nvmData = nvmErased ? `BMLP_ERASED : nvmRawData;

// ----------------------------------------
// register read
// ----------------------------------------
always_ff @(posedge ref_clk or negedge rst_n) begin
  if (!rst_n) begin
    regRdata <= 8'h00;
  end else if (regRe) begin
    unique case (regAddr)
      `BMLP_ADDR_CTRL: regRdata <= {6'h00, xie_r, slow_r};
      `BMLP_ADDR_STAT: regRdata <= {1'b0, lp_r, loadDone_r, started_r, mode_r};
      `BMLP_ADDR_LOAD: regRdata <= got_r;
      default: regRdata <= 8'h00;
    endcase
  end else begin
    regRdata <= 8'h00;
  end
end

// ----------------------------------------
// checks
// ----------------------------------------
default clocking cb @(posedge ref_clk); endclocking
default disable iff (!rst_n);

AST_MODE_HELD: assert property (captured_r |=> $stable(mode_r))
  else $error("mode changed after capture");
AST_SECURE_BLOCK: assert property (!captured_r && !securityOptionBit |=> mode_r != BMLP_LOADER)
  else $error("loader entered while secure");
AST_OSC_OFF: assert property (stopEnter |=> !lpOut.oscOn && !busClkEn)
  else $error("oscillator still running in stop");
AST_STOP_WAKE: assert property (lp_r == LP_STOP && !stopWake |=> lp_r == LP_STOP)
  else $error("stop left without wake source");
AST_SLOW_CLR: assert property (stopEnter |=> !slow_r && clearIMask)
  else $error("stop entry did not clear bits");
AST_STACK_LATE: assert property (lp_r == LP_RESUME |=> stackReq && execStart && execAddr == `BMLP_VEC_IRQ)
  else $error("stop wake not stacked and vectored");
AST_STAB_HOLD: assert property ($rose(lp_r == LP_STAB) |-> lpOut.cpuHold [*8])
  else $error("cpu released during stabilisation");
AST_WAIT_EXIT: assert property (lp_r == LP_WAIT && irqIn.timer |=> lp_r == LP_RUN ##0 stackReq)
  else $error("wait not left on timer interrupt");
AST_RAM_BASE: assert property (ramWr.we && got_r == 8'h01 |-> ramWr.addr == `BMLP_RAM_BASE)
  else $error("first byte not at ram base");
AST_JUMP: assert property (execStart && mode_r == BMLP_JUMP && !$past(lp_r == LP_RESUME)
  |-> $past(portA) == `BMLP_JUMP_KEY && execAddr == {$past(portB), $past(portC)})
  else $error("jump taken without key or wrong address");
AST_NVM_ERASED: assert property (nvmErased |-> nvmData == `BMLP_ERASED)
  else $error("erased nvm not ff");

endmodule

// file: hw/bmlp_defines.svh
// constants for the boot mode and low power block
// assumes ref_clk at 20 MHz is the oscillator clock
`ifndef BMLP_DEFINES_SVH
`define BMLP_DEFINES_SVH
`define BMLP_CLK_HZ 20000000
`define BMLP_BAUD 9600
`define BMLP_BIT_CYC (`BMLP_CLK_HZ / `BMLP_BAUD)
`define BMLP_HALF_CYC (`BMLP_BIT_CYC / 2)
`define BMLP_RAM_BASE 16'h0050
`define BMLP_PROG_START 16'h0051
`define BMLP_JUMP_KEY 8'hcc
`define BMLP_ERASED 8'hff
`define BMLP_VEC_IRQ 16'h1ffa
`define BMLP_VEC_RST 16'h1ffe
`define BMLP_STAB_SHORT 12'h010
`define BMLP_STAB_LONG 12'hfe0
`define BMLP_DIV_NORM 5'h01
`define BMLP_DIV_SLOW 5'h1f
`define BMLP_ADDR_CTRL 4'h0
`define BMLP_ADDR_STAT 4'h4
`define BMLP_ADDR_LOAD 4'h8
`define BMLP_CTRL_SLOW 0
`define BMLP_CTRL_XIE 1
`endif

// file: hw/bmlp_pkg.sv
// types for the boot mode and low power block
// assumes bmlp_defines.svh for numeric constants
package bmlp_pkg;
  typedef enum logic [1:0] {BMLP_SINGLE, BMLP_LOADER, BMLP_JUMP, BMLP_BLOCKED} bmlp_mode_t;
  typedef enum logic [2:0] {LP_RUN, LP_STOP, LP_STAB, LP_WAIT, LP_RESUME} bmlp_lp_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} bmlp_rx_t;
  typedef struct packed {
    logic wake;
    logic timer;
    logic sci;
  } bmlp_irq_t;
  typedef struct packed {
    logic we;
    logic [15:0] addr;
    logic [7:0] data;
  } bmlp_ram_t;
  typedef struct packed {
    logic oscOn;
    logic cpuHold;
    logic periphHalt;
    logic wdogClear;
    logic nvmReadOnly;
    logic pulseLenHold;
  } bmlp_lp_out_t;
endpackage

// file: sim/bmlp_host_model.sv
// serial host model feeding the boot loader
// assumes the bench calls send_byte from its own sequence
`timescale 1ns/1ns
module bmlp_host_model #(
  parameter int BIT_CYC = 2083
) (
  input wire logic ref_clk,
  output logic serialRx
);
  // ----------------------------------------
  // line idles high between frames
  // ----------------------------------------
  initial begin
    serialRx = 1'b1;
  end

  // ----------------------------------------
  // one 8n1 frame, lsb first, after an idle gap
  // ----------------------------------------
  task send_byte(input logic [7:0] b, input int gap);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    repeat (gap) @(posedge ref_clk);
    for (int i = 0; i < 10; i++) begin
      @(posedge ref_clk);
      serialRx <= frame[i];
      repeat (BIT_CYC - 1) @(posedge ref_clk);
    end
  endtask
endmodule

// file: sim/tb_bmlp_boot_lp.sv
// bench for the boot mode and low power block
// assumes the host model and the design files compile first
`timescale 1ns/1ns
`include "bmlp_defines.svh"
module tb_bmlp_boot_lp;
  import bmlp_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic irqHighVolt, captureOneInput, bootStrapHigh, bootStrapLow, securityOptionBit;
  logic [7:0] portA, portB, portC, nvmRawData, regWdata, regRdata, nvmData;
  logic serialRx, stopExec, waitExec, nvmErased, regWe, regRe;
  logic execStart, clearIMask, stackReq, busClkEn;
  logic [3:0] regAddr;
  logic [15:0] execAddr, lastExec;
  bmlp_irq_t irqIn;
  bmlp_ram_t ramWr;
  bmlp_lp_out_t lpOut;
  bmlp_mode_t bootMode;
  int fail_count = 0;
  int checks = 0;
  int cycles = 0;
  int nExec = 0;
  int nClr = 0;
  int nStack = 0;
  logic [15:0] wa[$];
  logic [7:0] wd[$];

  bmlp_boot_lp #(.LONG_STAB(1'b0), .WDOG_IN_WAIT(1'b0)) u_bmlp_boot_lp (.ref_clk(ref_clk), .rst_n(rst_n),
    .irqHighVolt(irqHighVolt), .captureOneInput(captureOneInput), .bootStrapHigh(bootStrapHigh),
    .bootStrapLow(bootStrapLow), .securityOptionBit(securityOptionBit), .portA(portA), .portB(portB),
    .portC(portC), .serialRx(serialRx), .stopExec(stopExec), .waitExec(waitExec), .irqIn(irqIn),
    .nvmErased(nvmErased), .nvmRawData(nvmRawData), .regAddr(regAddr), .regWdata(regWdata), .regWe(regWe),
    .regRe(regRe), .regRdata(regRdata), .ramWr(ramWr), .nvmData(nvmData), .execStart(execStart),
    .execAddr(execAddr), .clearIMask(clearIMask), .stackReq(stackReq), .busClkEn(busClkEn), .lpOut(lpOut),
    .bootMode(bootMode));
  bmlp_host_model #(.BIT_CYC(`BMLP_BIT_CYC)) u_bmlp_host_model (.ref_clk(ref_clk), .serialRx(serialRx));

  // ----------------------------------------
  // clock, timeout and output monitor
  // ----------------------------------------
  always #25 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 80000) begin
      fail_count++;
      conclude();
    end
  end

  always @(negedge ref_clk) begin
    if (ramWr.we === 1'b1) begin
      wa.push_back(ramWr.addr);
      wd.push_back(ramWr.data);
    end
    if (execStart === 1'b1) begin
      nExec++;
      lastExec = execAddr;
    end
    if (clearIMask === 1'b1) nClr++;
    if (stackReq === 1'b1) nStack++;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task conclude;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= d;
    regWe <= 1'b1;
    @(posedge ref_clk);
    regWe <= 1'b0;
  endtask

  task reg_rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    regAddr <= a;
    regRe <= 1'b1;
    @(posedge ref_clk);
    regRe <= 1'b0;
    #1 chk(regRdata, exp);
  endtask

  // pins are {irq high, capture, strap high, strap low}
  task do_reset(input logic [3:0] pins, input logic openBit, input int n);
    @(posedge ref_clk);
    {irqHighVolt, captureOneInput, bootStrapHigh, bootStrapLow} <= pins;
    securityOptionBit <= openBit;
    portA <= 8'h00;
    rst_n <= 1'b0;
    cyc(n);
    nExec = 0;
    rst_n <= 1'b1;
    cyc(64);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task test_modes;
    logic [3:0] pins[3] = '{4'b0011, 4'b1111, 4'b1110};
    logic openBits[3] = '{1'b1, 1'b1, 1'b0};
    bmlp_mode_t md[3] = '{BMLP_SINGLE, BMLP_JUMP, BMLP_BLOCKED};
    logic [15:0] ad[3] = '{16'h1ffe, 16'h1234, 16'h1ffe};
    for (int i = 0; i < 3; i++) begin
      do_reset(pins[i], openBits[i], 4);
      chk(bootMode, md[i]);
      chk(nExec, (i == 1) ? 0 : 1);
      @(posedge ref_clk);
      portA <= `BMLP_JUMP_KEY;
      {irqHighVolt, captureOneInput, bootStrapHigh, bootStrapLow} <= ~pins[i];
      cyc(5);
      chk(bootMode, md[i]);
      chk(nExec, 1);
      chk(lastExec, ad[i]);
    end
  endtask

  task test_nvm;
    @(posedge ref_clk);
    nvmErased <= 1'b1;
    nvmRawData <= 8'h5a;
    #1 chk(nvmData, 8'hff);
    @(posedge ref_clk);
    nvmErased <= 1'b0;
    #1 chk(nvmData, 8'h5a);
  endtask

  task test_slow;
    int n;
    n = 0;
    reg_wr(`BMLP_ADDR_CTRL, 8'h03);
    reg_rd(`BMLP_ADDR_CTRL, 8'h03);
    for (int i = 0; i < 64; i++) begin
      @(posedge ref_clk);
      #1 n += busClkEn;
    end
    chk(n, 2);
    reg_rd(4'hc, 8'h00);
  endtask

  task test_stop;
    int n;
    n = 0;
    nClr = 0;
    nStack = 0;
    @(posedge ref_clk);
    stopExec <= 1'b1;
    @(posedge ref_clk);
    stopExec <= 1'b0;
    irqIn <= 3'b011;
    cyc(20);
    irqIn <= 3'b100;
    #1 chk(lpOut, 6'b011111);
    chk(busClkEn, 1'b0);
    chk(nClr, 1);
    chk(nStack, 0);
    while (n < 200 && stackReq !== 1'b1) begin
      @(posedge ref_clk);
      #1 n++;
    end
    chk(n >= 32 && n <= 40, 1);
    @(posedge ref_clk);
    irqIn <= 3'b000;
    cyc(1);
    chk(lastExec, `BMLP_VEC_IRQ);
    reg_rd(`BMLP_ADDR_CTRL, 8'h02);
  endtask

  task test_wait;
    for (int k = 0; k < 3; k++) begin
      nClr = 0;
      nStack = 0;
      @(posedge ref_clk);
      waitExec <= 1'b1;
      @(posedge ref_clk);
      waitExec <= 1'b0;
      cyc(3);
      irqIn <= 3'b001 << k;
      #1 chk(lpOut, 6'b110100);
      chk(nClr, 1);
      chk(nStack, 0);
      cyc(4);
      irqIn <= 3'b000;
      #1 chk(nStack, 1);
      chk(lpOut, 6'b100000);
    end
    reg_rd(`BMLP_ADDR_CTRL, 8'h02);
    reg_wr(`BMLP_ADDR_CTRL, 8'h01);
    @(posedge ref_clk);
    waitExec <= 1'b1;
    @(posedge ref_clk);
    waitExec <= 1'b0;
    do_reset(4'b0011, 1'b1, 4);
    chk(lpOut, 6'b100000);
    reg_rd(`BMLP_ADDR_CTRL, 8'h02);
  endtask

  task test_loader;
    logic [7:0] bytes[3] = '{8'h03, 8'ha5, 8'h3c};
    do_reset(4'b1110, 1'b1, 4);
    chk(bootMode, BMLP_LOADER);
    wa.delete();
    wd.delete();
    u_bmlp_host_model.send_byte(bytes[0], 0);
    u_bmlp_host_model.send_byte(bytes[1], 100);
    cyc(3000);
    chk(nExec, 0);
    reg_rd(`BMLP_ADDR_LOAD, 8'h02);
    u_bmlp_host_model.send_byte(bytes[2], 0);
    cyc(100);
    chk(wa.size(), 3);
    for (int i = 0; i < 3; i++) begin
      chk(wa[i], `BMLP_RAM_BASE + i);
      chk(wd[i], bytes[i]);
    end
    chk(nExec, 1);
    chk(lastExec, `BMLP_PROG_START);
    reg_rd(`BMLP_ADDR_STAT, 8'h0d);
    reg_rd(`BMLP_ADDR_LOAD, 8'h03);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {irqHighVolt, captureOneInput, bootStrapHigh, bootStrapLow, securityOptionBit} = 5'b00111;
    portA = 8'h00;
    portB = 8'h12;
    portC = 8'h34;
    {stopExec, waitExec, nvmErased, regWe, regRe} = 5'b00000;
    nvmRawData = 8'h00;
    regWdata = 8'h00;
    regAddr = 4'h0;
    irqIn = 3'b000;
    do_reset(4'b0011, 1'b1, 12);
    test_modes();
    test_nvm();
    test_slow();
    test_stop();
    test_wait();
    test_loader();
    conclude();
  end
endmodule
